// [common/falut_pkg.sv]
`default_nettype none
package falut_pkg;
    localparam int unsigned PIX_W = 12;
    localparam int unsigned ACC_W = 20;
    localparam int unsigned TBL_ENTRIES = 512;
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned CNT_W = 9;
    localparam logic [8:0] AVG_MAX = 9'h100;
    localparam logic [8:0] AVG_MIN = 9'h001;
    localparam logic [8:0] CNT_RST = 9'h001;
    localparam logic [11:0] LAST_ENTRY = 12'hff8;
    localparam logic [8:0] LAST_SEG = 9'h1ff;
    localparam logic [7:0] SEL_LUMA = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_AVG_COUNT = 8'h04;
    localparam logic [7:0] REG_TBL_SEL = 8'h08;
    localparam logic [7:0] REG_TBL_INDEX = 8'h0c;
    localparam logic [7:0] REG_TBL_VALUE = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_ACQ_START = 8'h18;

    typedef struct packed {
        logic chunk_en;
        logic event_en;
        logic single_frame;
        logic out_8bit;
        logic map_en;
    } falut_ctrl_t;

    localparam falut_ctrl_t CTRL_RST = '0;

    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [11:0] data;
    } falut_pix_t;
endpackage
`default_nettype wire

// [rtl/falut_top.sv]
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module falut_top
    import falut_pkg::*;
#(
    parameter int unsigned FRAME_PIXELS = 64,
    parameter int unsigned CHUNK_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire falut_pix_t pix_in,
    output falut_pix_t pix_out,
    input wire logic exposure_end_in,
    output logic exposure_event_out,
    input wire logic [CHUNK_W-1:0] chunk_in,
    output logic [CHUNK_W-1:0] chunk_out,
    output logic chunk_out_valid
);
    localparam int unsigned IDX_W = (FRAME_PIXELS > 1) ? $clog2(FRAME_PIXELS) : 1;
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(FRAME_PIXELS - 1);

    // register file
    falut_ctrl_t ctrl_r, ctrl_nxt;
    logic [CNT_W-1:0] count_r, count_nxt;
    logic [11:0] index_r, index_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic tbl_we;
    logic arm_req;
    logic [11:0] tbl_r [0:TBL_ENTRIES-1];

    // averaging state
    logic [ACC_W-1:0] acc_r [0:FRAME_PIXELS-1];
    logic [8:0] img_k_r, img_k_nxt;
    logic last_r, last_nxt;
    logic take_r, take_nxt;
    logic armed_r, armed_nxt;
    logic [IDX_W-1:0] idx_r, idx_nxt;
    falut_pix_t stage_r, stage_nxt;
    logic event_r, event_nxt;
    logic [CHUNK_W-1:0] chunk_r, chunk_nxt;
    logic chunk_v_r, chunk_v_nxt;
    logic cur_take, cur_last, acc_we;
    logic [IDX_W-1:0] cur_idx;
    logic [ACC_W-1:0] prev_sum, sum;
    logic [8:0] div;

    // mapping stage
    falut_pix_t out_r, out_nxt;
    logic [8:0] seg;
    logic [2:0] frac;
    logic [11:0] lut_lo, lut_hi, lut_val, mapped;
    logic [15:0] blend;

    always_comb begin
        ctrl_nxt = ctrl_r;
        count_nxt = count_r;
        index_nxt = index_r;
        rdata_nxt = '0;
        tbl_we = 1'b0;
        arm_req = 1'b0;
        if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl_nxt = reg_wdata[CTRL_W-1:0];
            end else if (reg_addr == REG_AVG_COUNT) begin
                if (reg_wdata == 32'h0) begin
                    count_nxt = AVG_MIN;
                end else if (reg_wdata > {23'h0, AVG_MAX}) begin
                    count_nxt = AVG_MAX;
                end else begin
                    count_nxt = reg_wdata[CNT_W-1:0];
                end
            end else if (reg_addr == REG_TBL_INDEX) begin
                index_nxt = reg_wdata[11:0];
            end else if (reg_addr == REG_TBL_VALUE) begin
                // unused locations take no storage and drop their writes
                tbl_we = (index_r[2:0] == 3'h0);
            end else if (reg_addr == REG_ACQ_START) begin
                arm_req = 1'b1;
            end
        end
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                rdata_nxt = {27'h0, ctrl_r};
            end else if (reg_addr == REG_AVG_COUNT) begin
                rdata_nxt = {23'h0, count_r};
            end else if (reg_addr == REG_TBL_SEL) begin
                rdata_nxt = {24'h0, SEL_LUMA};
            end else if (reg_addr == REG_TBL_INDEX) begin
                rdata_nxt = {20'h0, index_r};
            end else if (reg_addr == REG_TBL_VALUE) begin
                if (index_r[2:0] == 3'h0) begin
                    rdata_nxt = {20'h0, tbl_r[index_r[11:3]]};
                end
            end else if (reg_addr == REG_STATUS) begin
                rdata_nxt = {21'h0, take_r, armed_r, img_k_r};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            count_r <= CNT_RST;
            index_r <= '0;
            rdata_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            count_r <= count_nxt;
            index_r <= index_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // table selector holds only the luminance table, so no select gating
    always_ff @(posedge clk) begin
        if (tbl_we) begin
            tbl_r[index_r[11:3]] <= reg_wdata[11:0];
        end
    end

    assign reg_rdata = rdata_r;

    // count is sampled at every frame start, so a change hits the next image
    always_comb begin
        cur_take = pix_in.sof ? (armed_r || !ctrl_r.single_frame) : take_r;
        cur_last = pix_in.sof ? ({1'b0, img_k_r} + 10'h001 >= {1'b0, count_r}) : last_r;
        cur_idx = pix_in.sof ? '0 : idx_r;
        prev_sum = (img_k_r == 9'h0) ? '0 : acc_r[cur_idx];
        sum = prev_sum + ACC_W'(pix_in.data);
        div = img_k_r + 9'h001;
        take_nxt = take_r;
        last_nxt = last_r;
        idx_nxt = idx_r;
        img_k_nxt = img_k_r;
        armed_nxt = armed_r;
        acc_we = 1'b0;
        stage_nxt = '0;
        chunk_nxt = chunk_r;
        chunk_v_nxt = 1'b0;
        event_nxt = exposure_end_in && ctrl_r.event_en;
        if (pix_in.valid && cur_take) begin
            take_nxt = 1'b1;
            last_nxt = cur_last;
            idx_nxt = (cur_idx == IDX_LAST) ? cur_idx : cur_idx + IDX_W'(1);
            acc_we = 1'b1;
            // quotient truncates, dropping the fraction
            stage_nxt.valid = cur_last;
            stage_nxt.sof = pix_in.sof;
            stage_nxt.eof = pix_in.eof;
            stage_nxt.data = PIX_W'(sum / ACC_W'(div));
            if (pix_in.eof) begin
                img_k_nxt = cur_last ? 9'h0 : img_k_r + 9'h001;
                take_nxt = 1'b0;
                if (cur_last && ctrl_r.single_frame) begin
                    armed_nxt = 1'b0;
                end
                if (cur_last && ctrl_r.chunk_en) begin
                    chunk_nxt = chunk_in;
                    chunk_v_nxt = 1'b1;
                end
            end
        end else if (pix_in.valid && pix_in.sof) begin
            take_nxt = 1'b0;
        end
        // a start request beats a same-cycle disarm
        if (arm_req) begin
            armed_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            img_k_r <= '0;
            last_r <= 1'b0;
            take_r <= 1'b0;
            armed_r <= 1'b1;
            idx_r <= '0;
            stage_r <= '0;
            event_r <= 1'b0;
            chunk_r <= '0;
            chunk_v_r <= 1'b0;
        end else begin
            img_k_r <= img_k_nxt;
            last_r <= last_nxt;
            take_r <= take_nxt;
            armed_r <= armed_nxt;
            idx_r <= idx_nxt;
            stage_r <= stage_nxt;
            event_r <= event_nxt;
            chunk_r <= chunk_nxt;
            chunk_v_r <= chunk_v_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (acc_we) begin
            acc_r[cur_idx] <= sum;
        end
    end

    assign exposure_event_out = event_r;
    assign chunk_out = chunk_r;
    assign chunk_out_valid = chunk_v_r;

    always_comb begin
        seg = stage_r.data[11:3];
        frac = stage_r.data[2:0];
        lut_lo = tbl_r[seg];
        lut_hi = tbl_r[9'(seg + 9'h001)];
        // weighted sum fits 15 bits; shift truncates toward zero
        blend = 16'(lut_lo) * 16'(4'h8 - {1'b0, frac}) + 16'(lut_hi) * 16'(frac);
        if (seg == LAST_SEG) begin
            lut_val = lut_lo;
        end else begin
            lut_val = blend[14:3];
        end
        mapped = ctrl_r.map_en ? lut_val : stage_r.data;
        out_nxt = stage_r;
        out_nxt.data = ctrl_r.out_8bit ? {4'h0, mapped[11:4]} : mapped;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign pix_out = out_r;

    sequence s_last_eof;
        pix_in.valid && pix_in.eof && cur_take && cur_last;
    endsequence

    sequence s_mid_pixel;
        pix_in.valid && cur_take && !cur_last;
    endsequence

    a_count_range: assert property (@(posedge clk) disable iff (!rst_n)
        count_r >= AVG_MIN && count_r <= AVG_MAX)
        else $error("averaging count out of range");

    a_pass_single: assert property (@(posedge clk) disable iff (!rst_n)
        (pix_in.valid && cur_take && pix_in.sof && count_r == AVG_MIN)
        |=> stage_r.valid && stage_r.data == $past(pix_in.data))
        else $error("count one does not pass pixel through");

    a_hold_midseq: assert property (@(posedge clk) disable iff (!rst_n)
        s_mid_pixel |=> !stage_r.valid ##1 !pix_out.valid)
        else $error("output during unfinished sequence");

    a_single_once: assert property (@(posedge clk) disable iff (!rst_n)
        (s_last_eof ##0 (ctrl_r.single_frame && !arm_req)) |=> !armed_r)
        else $error("single frame mode did not stop");

    a_raw_path: assert property (@(posedge clk) disable iff (!rst_n)
        (!ctrl_r.map_en && !ctrl_r.out_8bit) |=> pix_out.data == $past(stage_r.data))
        else $error("raw path altered pixel");

    a_top_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_r.map_en && !ctrl_r.out_8bit && stage_r.data >= LAST_ENTRY)
        |=> pix_out.data == $past(tbl_r[LAST_SEG]))
        else $error("value above last entry not clamped");

    a_exact_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_r.map_en && !ctrl_r.out_8bit && frac == 3'h0)
        |=> pix_out.data == $past(lut_lo))
        else $error("aligned value not taken from entry");

    a_interp_bound: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_r.map_en && !ctrl_r.out_8bit && seg != LAST_SEG)
        |=> (pix_out.data >= $past(lut_lo) || pix_out.data >= $past(lut_hi))
        && (pix_out.data <= $past(lut_lo) || pix_out.data <= $past(lut_hi)))
        else $error("interpolation outside neighbours");

    a_eight_bit: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_r.map_en && ctrl_r.out_8bit && frac == 3'h0)
        |=> pix_out.data == {4'h0, $past(lut_lo[11:4])})
        else $error("8-bit output not upper bits of mapped value");

    a_event_each: assert property (@(posedge clk) disable iff (!rst_n)
        exposure_event_out == $past(exposure_end_in && ctrl_r.event_en))
        else $error("exposure event not one per image");

    a_chunk_last: assert property (@(posedge clk) disable iff (!rst_n)
        (s_last_eof ##0 ctrl_r.chunk_en) |=> chunk_out_valid && chunk_out == $past(chunk_in))
        else $error("chunk not from final image");
endmodule
`default_nettype wire

// [tb/falut_sensor_model.sv]
`timescale 1ns/10ps
`default_nettype none
module falut_sensor_model
    import falut_pkg::*;
#(
    parameter int unsigned FRAME_PIXELS = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [11:0] base,
    output falut_pix_t pix,
    output logic exp_end,
    output logic busy
);
    int unsigned idx;
    always @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            exp_end <= 1'b0;
            pix <= '0;
        end else if (busy) begin
            pix.valid <= 1'b1;
            pix.sof <= (idx == 0);
            pix.eof <= (idx == FRAME_PIXELS - 1);
            pix.data <= base + 12'(idx * 37);
            // one exposure end and one frame per trigger
            exp_end <= (idx == FRAME_PIXELS - 1);
            idx <= idx + 1;
            busy <= (idx != FRAME_PIXELS - 1);
        end else begin
            // idle data toggles so a stale beat is never mistaken for a pixel
            exp_end <= 1'b0;
            pix <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~pix.data};
            if (go) begin
                busy <= 1'b1;
                idx <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    import falut_pkg::*;
    localparam int unsigned FP = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic go = 1'b0;
    logic [11:0] base = '0;
    logic [31:0] chunk_in = '0;
    logic [31:0] reg_rdata, chunk_out;
    logic exp_end, ev_out, busy, chunk_v;
    falut_pix_t pix_in, pix_out;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 47;
    int ev_seen = 0, chunk_seen = 0, frames = 0, outs = 0;
    logic [11:0] tbl [512];
    logic [13:0] expq [$];
    logic [13:0] seen_px;
    logic [19:0] acc [FP];

    initial forever #2 clk = ~clk;

    falut_top #(.FRAME_PIXELS(FP), .CHUNK_W(32)) dut (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out), .exposure_end_in(exp_end),
        .exposure_event_out(ev_out), .chunk_in(chunk_in), .chunk_out(chunk_out),
        .chunk_out_valid(chunk_v));
    falut_sensor_model #(.FRAME_PIXELS(FP)) sensor (.clk(clk), .rst_n(rst_n), .go(go),
        .base(base), .pix(pix_in), .exp_end(exp_end), .busy(busy));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [11:0] xform(input logic [11:0] x, input logic m, input logic b8);
        logic [11:0] v;
        logic [15:0] s;
        v = x;
        if (m && x >= 12'hff8) v = tbl[511];
        else if (m) begin
            s = 16'(tbl[x[11:3]]) * (16'h8 - 16'(x[2:0])) + 16'(tbl[x[11:3] + 1]) * 16'(x[2:0]);
            v = s[14:3];
        end
        return b8 ? {4'h0, v[11:4]} : v;
    endfunction

    always @(posedge clk) begin
        if (ev_out === 1'b1) ev_seen++;
        if (chunk_v === 1'b1) chunk_seen++;
        if (pix_out.valid === 1'b1 && expq.size() == 0) check(1, 0, "extra pixel");
        else if (pix_out.valid === 1'b1) begin
            seen_px = {pix_out.sof, pix_out.eof, pix_out.data};
            check(seen_px, expq.pop_front(), "pixel");
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic send(input logic [11:0] b);
        @(posedge clk);
        go <= 1'b1;
        base <= b;
        chunk_in <= {20'h0, b};
        @(posedge clk);
        go <= 1'b0;
        frames++;
        for (int t = 0; t <= FP + 4; t++) begin
            @(posedge clk);
            if (busy === 1'b0) return;
        end
        check(1, 0, "frame timeout");
        tally_and_finish();
    endtask

    // a fixed base forces the top-of-range pixel at the first beat
    task automatic run_seq(input int n, input logic m, input logic b8, input logic ex,
                           input logic [11:0] fixb, input logic [31:0] cut);
        logic [11:0] b;
        logic [11:0] p;
        logic [11:0] q;
        for (int k = 0; k < n; k++) begin
            b = (fixb != 0) ? fixb : 12'($random(seed));
            for (int i = 0; i < FP; i++) begin
                // sensor data wraps at 12 bits, so the sum must see the wrapped value
                p = b + 12'(i * 37);
                acc[i] = (k == 0 ? 20'h0 : acc[i]) + 20'(p);
                if (k == n - 1 && ex) begin
                    q = xform(12'(acc[i] / n), m, b8);
                    expq.push_back({i == 0, i == FP - 1, q});
                end
            end
            send(b);
            // deliberate change inside a sequence: the next image must already use it
            if (k == 0 && cut != 0) wr(REG_AVG_COUNT, cut);
        end
        if (ex) outs++;
    endtask

    initial begin
        logic [31:0] d;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_TBL_SEL, d);
        check(d, 32'h0, "selector");
        rd(8'h40, d);
        check(d, 32'h0, "unmapped");
        wr(REG_AVG_COUNT, 32'h1ff);
        rd(REG_AVG_COUNT, d);
        check(d, 32'h100, "count clamp");
        wr(REG_AVG_COUNT, 32'h0);
        rd(REG_AVG_COUNT, d);
        check(d, 32'h1, "count floor");
        for (int k = 0; k < 512; k++) begin
            tbl[k] = 12'($random(seed));
            wr(REG_TBL_INDEX, 32'(k * 8));
            wr(REG_TBL_VALUE, 32'(tbl[k]));
        end
        wr(REG_TBL_INDEX, 32'hc);
        wr(REG_TBL_VALUE, 32'h5a5);
        rd(REG_TBL_VALUE, d);
        check(d, 32'h0, "unaligned entry");
        wr(REG_TBL_INDEX, 32'h8);
        rd(REG_TBL_VALUE, d);
        check(d, 32'(tbl[1]), "entry 8");
        // settings change only between sequences; mode 4 maps the top-of-range base
        for (int mode = 0; mode < 5; mode++) begin
            wr(REG_CTRL, 32'h18 | 32'(mode & 3) | 32'(mode >> 2));
            wr(REG_AVG_COUNT, (mode == 2) ? 32'h100 : 32'(mode + 1));
            run_seq((mode == 2) ? 256 : mode + 1, mode[0] | mode[2], mode[1], 1'b1,
                    (mode == 4) ? 12'hff8 : 12'h0, 32'h0);
            repeat (4) @(posedge clk);
            check(chunk_out, chunk_in, "chunk");
        end
        wr(REG_CTRL, 32'h18);
        wr(REG_AVG_COUNT, 32'h3);
        run_seq(2, 1'b0, 1'b0, 1'b1, 12'h0, 32'h2);
        repeat (4) @(posedge clk);
        check(chunk_out, chunk_in, "chunk after cut");
        wr(REG_ACQ_START, 32'h1);
        wr(REG_CTRL, 32'h1d);
        wr(REG_AVG_COUNT, 32'h2);
        run_seq(2, 1'b1, 1'b0, 1'b1, 12'h0, 32'h0);
        run_seq(2, 1'b1, 1'b0, 1'b0, 12'h0, 32'h0);
        rd(REG_STATUS, d);
        check(d, 32'h0, "disarmed status");
        wr(REG_ACQ_START, 32'h1);
        rd(REG_STATUS, d);
        check(d, 32'h200, "armed status");
        run_seq(2, 1'b1, 1'b0, 1'b1, 12'h0, 32'h0);
        repeat (8) @(posedge clk);
        check(expq.size(), 0, "missing pixels");
        check(ev_seen, frames, "events");
        check(chunk_seen, outs, "chunk pulses");
        tally_and_finish();
    end
endmodule
`default_nettype wire
